/* pkg/agq_pkg.sv */
/*
  Constants, types and register map for the alarm group event queue block.
  Assumes one 25 MHz clock; all timers count a shared 1 ms tick.
*/
// Notes on behaviour
// [RQ1] a record is built whenever any setpoint enters alarm or returns to normal
// [RQ2] record fields: type 1, date, time, millis, word, bit, state, node
// [RQ3] records go only into output queue 0
// [RQ4] queue 0 has four heads, each delivering every record to its own node
// [RQ5] a disabled head sends nothing
// [RQ6] each head sends to its primary while that link is healthy
// [RQ7] after a primary failure the head sends to its secondary
// [RQ8] in fallback the head periodically retries the primary, then resumes there
// [RQ9] each head chooses to drop oldest or newest records on overflow
// [RQ10] a bank of 16-bit status words tracks run-time state, readable by peers
// [RQ11] peers may subscribe to status words; device only flags changes
// [RQ12] setpoint 1 of all inputs feeds group output 1, setpoint 2 group output 2
// [RQ13] group outputs idle energised; follow input, follow alarm or reflash
// [RQ14] follow input: off on any abnormal, on when all normal
// [RQ15] follow alarm: off on any alarm, on once all sequences are reset
// [RQ16] reflash: first abnormal de-energises, later ones pulse on about 1 s
// [RQ17] lamp and buzzer sequence: follow input, fleeting auto or manual reset
// [RQ18] displayed input steps every 5 s or 15 s, or not at all
// [RQ19] setpoints are high or low each, sharing one hysteresis band
// [RQ20] record time stamp is taken when the change is detected
// [RQ21] follow input: lamp lit while abnormal; buzzer on new alarm until silenced
package agq_pkg;
  // timing
  localparam int CLK_NS = 40;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int REFLASH_MS = 1000;
  localparam int FLASH_MS = 500;
  localparam int SCROLL5_MS = 5000;
  localparam int SCROLL15_MS = 15000;
  localparam int RETRY_MS = 1000;
  localparam int HEADS = 4;
  // register byte addresses
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_NODE = 12'h004;
  localparam logic [11:0] A_HYST = 12'h008;
  localparam logic [11:0] A_SPTYPE = 12'h00C;
  localparam logic [11:0] A_HEAD = 12'h010;
  localparam logic [11:0] A_STAT = 12'h040;
  localparam logic [11:0] A_SP = 12'h100;
  // field positions and reset values
  localparam int CTRL_GA_LSB = 0;
  localparam int CTRL_SEQ_LSB = 2;
  localparam int CTRL_SCR_LSB = 4;
  localparam int H_PRI_LSB = 0;
  localparam int H_SEC_LSB = 8;
  localparam int H_EN_BIT = 16;
  localparam int H_DNEW_BIT = 17;
  localparam logic [6:0] NODE_RST = 7'h01;
  localparam logic [15:0] HYST_RST = 16'h0000;
  // status table words
  localparam int ST_WORDS = 6;
  localparam logic [15:0] ST_SP1 = 16'h0000;
  localparam logic [15:0] ST_SP2 = 16'h0001;
  localparam logic [7:0] REC_TYPE = 8'h01;
  localparam logic [7:0] STATE_ABN = 8'hFF;
  localparam logic [7:0] STATE_NRM = 8'h00;
  typedef enum logic [1:0] {GA_FOLLOW_IN = 2'h0, GA_FOLLOW_ALM = 2'h1, GA_REFLASH = 2'h2} agq_ga_e;
  typedef enum logic [1:0] {SEQ_FOLLOW = 2'h0, SEQ_AUTO = 2'h1, SEQ_MANUAL = 2'h2} agq_seq_e;
  typedef enum logic [1:0] {SCR_OFF = 2'h0, SCR_5S = 2'h1, SCR_15S = 2'h2} agq_scr_e;
  typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_SEND = 3'b010, TX_GAP = 3'b100} agq_tx_e;
  typedef struct packed {
    logic [7:0] year, month, day, hour, minute, second;
    logic [15:0] msec;
  } agq_time_s;
  typedef struct packed {
    logic [7:0] rtype;
    agq_time_s stamp;
    logic [15:0] word;
    logic [7:0] bitn, state, node;
  } agq_rec_s;
endpackage : agq_pkg

/* pkg/agq_grp_if.sv */
/*
  Carrier between the top and one group alarm output.
  Assumes all signals share the block clock.
*/
`timescale 1ns/1ns
interface agq_grp_if #(parameter int N = 16);
  logic [N-1:0] abn;
  logic [N-1:0] act;
  logic tick;
  logic [1:0] mode;
  logic energised;
  modport src (output abn, act, tick, mode, input energised);
  modport grp (input abn, act, tick, mode, output energised);
endinterface : agq_grp_if

/* rtl/agq_sp_cmp.sv */
/*
  One setpoint comparator with a hysteresis band.
  Assumes value and limit are unsigned and sampled on the scan strobe.
*/
`timescale 1ns/1ns
module agq_sp_cmp #(parameter int W = 16) (
  // clocking
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // sample
  input wire logic sample,
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] limit,
  input wire logic [W-1:0] hyst,
  input wire logic is_high,
  // state
  output logic abnormal
);
  logic [W:0] v_plus_h;
  logic [W:0] l_plus_h;

  // one bit wider so the band never wraps
  assign v_plus_h = {1'b0, value} + {1'b0, hyst};
  assign l_plus_h = {1'b0, limit} + {1'b0, hyst};

  // set at the limit, clear only beyond the band
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      abnormal <= 1'b0;
    end else if (ce && sample) begin
      if (is_high) begin
        if (value >= limit) abnormal <= 1'b1; // [RQ19]
        else if (v_plus_h < {1'b0, limit}) abnormal <= 1'b0; // [RQ19]
      end else begin
        if (value <= limit) abnormal <= 1'b1; // [RQ19]
        else if ({1'b0, value} > l_plus_h) abnormal <= 1'b0; // [RQ19]
      end
    end
  end
endmodule : agq_sp_cmp

/* rtl/agq_group_out.sv */
/*
  One group alarm output with three selectable behaviours.
  Assumes tick is a one-cycle pulse every millisecond.
*/
`timescale 1ns/1ns
module agq_group_out #(parameter int N = 16) (
  // clocking
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // group
  agq_grp_if.grp g
);
  logic [N-1:0] prev;
  logic [15:0] rf_cnt;

  // energised is the idle level; all modes drop it on alarm
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      g.energised <= 1'b1; // [RQ13]
      prev <= '0;
      rf_cnt <= 16'h0000;
    end else if (ce) begin
      prev <= g.abn;
      case (g.mode)
        agq_pkg::GA_FOLLOW_ALM: g.energised <= ~|g.act; // [RQ15]
        agq_pkg::GA_REFLASH: begin
          if (~|g.abn) begin
            g.energised <= 1'b1;
            rf_cnt <= 16'h0000;
          end else if (|(g.abn & ~prev)) begin
            g.energised <= |prev; // [RQ16]
            rf_cnt <= |prev ? 16'(agq_pkg::REFLASH_MS) : 16'h0000;
          end else if (rf_cnt != 16'h0000) begin
            if (g.tick) rf_cnt <= rf_cnt - 16'h0001;
            if (g.tick && rf_cnt == 16'h0001) g.energised <= 1'b0; // [RQ16]
          end else begin
            g.energised <= 1'b0;
          end
        end
        default: g.energised <= ~|g.abn; // [RQ14]
      endcase
    end
  end
endmodule : agq_group_out

/* rtl/agq_top.sv */
/*
  Alarm event handling: setpoint compare, event records, four-head queue
  transmitter, status table, group outputs, lamp sequences and auto-scroll.
  Assumes scan values, time of day, link answers and register strobes come
  from logic on clk; only the front panel keys are asynchronous.
*/
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module agq_top #(
  parameter int N = 16,
  parameter int DEPTH = 8,
  parameter int TICK_CYC = agq_pkg::TICK_CYC
) (
  // clocking
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // scanned inputs
  input wire logic [N*16-1:0] in_value,
  input wire logic in_valid,
  // time of day
  input wire agq_pkg::agq_time_s rtc_now,
  // front panel keys, asynchronous
  input wire logic key_silence,
  input wire logic key_ack,
  input wire logic key_reset,
  // queue link
  output logic tx_valid,
  output logic [1:0] tx_head,
  output logic [6:0] tx_dest,
  output agq_pkg::agq_rec_s tx_rec,
  input wire logic tx_ok,
  input wire logic tx_fail,
  // panel and field outputs
  output logic [1:0] group_alarm_output,
  output logic [2*N-1:0] lamp,
  output logic buzzer,
  output logic [3:0] disp_input,
  output logic table_change
);
  localparam int K = 2 * N;
  localparam int KW = $clog2(K);
  localparam int DW = $clog2(DEPTH);
  localparam int HEADS = agq_pkg::HEADS;

  // configuration
  logic [1:0] ga_mode, seq_mode, scr_mode;
  logic [6:0] node_addr;
  logic [15:0] hyst;
  logic [K-1:0] sp_type;
  logic [15:0] sp_val [K];
  logic [6:0] head_pri [HEADS];
  logic [6:0] head_sec [HEADS];
  logic [HEADS-1:0] head_en, head_dnew;
  logic [11:0] hd_off, sp_off;
  logic [1:0] hd_idx;
  logic [KW-1:0] sp_idx;
  logic [31:0] next_rdata;

  assign hd_off = reg_addr - agq_pkg::A_HEAD;
  assign sp_off = reg_addr - agq_pkg::A_SP;
  assign hd_idx = hd_off[3:2];
  assign sp_idx = sp_off[KW+1:2];

  // register writes; unmapped addresses are ignored
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ga_mode <= agq_pkg::GA_FOLLOW_IN;
      seq_mode <= agq_pkg::SEQ_FOLLOW;
      scr_mode <= agq_pkg::SCR_OFF;
      node_addr <= agq_pkg::NODE_RST;
      hyst <= agq_pkg::HYST_RST;
      sp_type <= '1;
      head_en <= '0;
      head_dnew <= '0;
      for (int h = 0; h < HEADS; h++) begin
        head_pri[h] <= 7'h00;
        head_sec[h] <= 7'h00;
      end
      for (int k = 0; k < K; k++) sp_val[k] <= 16'hFFFF;
    end else if (ce && reg_wr) begin
      if (reg_addr == agq_pkg::A_CTRL) begin
        ga_mode <= reg_wdata[agq_pkg::CTRL_GA_LSB +: 2];
        seq_mode <= reg_wdata[agq_pkg::CTRL_SEQ_LSB +: 2];
        scr_mode <= reg_wdata[agq_pkg::CTRL_SCR_LSB +: 2];
      end else if (reg_addr == agq_pkg::A_NODE) begin
        node_addr <= reg_wdata[6:0];
      end else if (reg_addr == agq_pkg::A_HYST) begin
        hyst <= reg_wdata[15:0]; // [RQ19]
      end else if (reg_addr == agq_pkg::A_SPTYPE) begin
        sp_type <= reg_wdata[K-1:0]; // [RQ19]
      end else if (hd_off < 12'(4 * HEADS) && hd_off[1:0] == 2'h0) begin
        head_pri[hd_idx] <= reg_wdata[agq_pkg::H_PRI_LSB +: 7]; // [RQ6]
        head_sec[hd_idx] <= reg_wdata[agq_pkg::H_SEC_LSB +: 7];
        head_en[hd_idx] <= reg_wdata[agq_pkg::H_EN_BIT]; // [RQ5]
        head_dnew[hd_idx] <= reg_wdata[agq_pkg::H_DNEW_BIT]; // [RQ9]
      end else if (sp_off < 12'(4 * K) && sp_off[1:0] == 2'h0) begin
        sp_val[sp_idx] <= reg_wdata[15:0];
      end
    end
  end

  // millisecond tick shared by every timer
  logic [15:0] tick_cnt;
  logic tick;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= tick_cnt == 16'(TICK_CYC - 1);
      tick_cnt <= tick_cnt == 16'(TICK_CYC - 1) ? 16'h0000 : tick_cnt + 16'h0001;
    end
  end

  // keys: two flip-flops, then a third for the edge
  logic [2:0] key_s1, key_s2, key_s3;
  logic sil_p, ack_p, rst_p;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      key_s1 <= 3'h0;
      key_s2 <= 3'h0;
      key_s3 <= 3'h0;
    end else if (ce) begin
      key_s1 <= {key_reset, key_ack, key_silence};
      key_s2 <= key_s1;
      key_s3 <= key_s2;
    end
  end
  assign sil_p = key_s2[0] & ~key_s3[0];
  assign ack_p = key_s2[1] & ~key_s3[1];
  assign rst_p = key_s2[2] & ~key_s3[2];

  // setpoint k = s*N + i compares input i against setpoint s
  logic [K-1:0] abn, prev_abn, chg, rise;
  for (genvar k = 0; k < K; k++) begin : g_cmp
    agq_sp_cmp #(.W(16)) u_cmp (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .sample(in_valid),
      .value(in_value[(k % N) * 16 +: 16]),
      .limit(sp_val[k]),
      .hyst(hyst),
      .is_high(sp_type[k]),
      .abnormal(abn[k])
    );
  end
  assign chg = abn ^ prev_abn;
  assign rise = abn & ~prev_abn;

  // lowest set bit, top bit flags that one was found
  function automatic logic [KW:0] first_set(input logic [K-1:0] v);
    first_set = '0;
    for (int i = K - 1; i >= 0; i--) begin
      if (v[i]) first_set = {1'b1, KW'(i)};
    end
  endfunction : first_set

  // pending changes; a change in the clearing cycle is kept
  logic [K-1:0] pend, pick_1h;
  logic [KW:0] pick;
  agq_pkg::agq_time_s rtc_q;
  agq_pkg::agq_rec_s rec;
  logic rec_push;
  assign pick = first_set(pend);
  assign pick_1h = pick[KW] ? K'(1) << pick[KW-1:0] : '0;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_abn <= '0;
      pend <= '0;
      rtc_q <= '0;
      rec <= '0;
      rec_push <= 1'b0;
    end else if (ce) begin
      prev_abn <= abn;
      rtc_q <= rtc_now; // [RQ20]
      pend <= (pend & ~pick_1h) | chg; // [RQ1]
      rec_push <= pick[KW]; // [RQ1]
      if (pick[KW]) begin
        rec.rtype <= agq_pkg::REC_TYPE; // [RQ2]
        rec.stamp <= rtc_q; // [RQ20]
        rec.word <= int'(pick[KW-1:0]) >= N ? agq_pkg::ST_SP2 : agq_pkg::ST_SP1;
        rec.bitn <= 8'(int'(pick[KW-1:0]) % N);
        rec.state <= abn[pick[KW-1:0]] ? agq_pkg::STATE_ABN : agq_pkg::STATE_NRM;
        rec.node <= {1'b0, node_addr};
      end
    end
  end

  // output queue 0: one ring per head, each head sees every record
  agq_pkg::agq_rec_s qmem [HEADS][DEPTH];
  logic [DW-1:0] qwp [HEADS];
  logic [DW-1:0] qrp [HEADS];
  logic [DW:0] qcnt [HEADS];
  logic [HEADS-1:0] pop, ovf;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ovf <= '0;
      for (int h = 0; h < HEADS; h++) begin
        qwp[h] <= '0;
        qrp[h] <= '0;
        qcnt[h] <= '0;
      end
    end else if (ce) begin
      for (int h = 0; h < HEADS; h++) begin
        if (!head_en[h]) begin
          qrp[h] <= qwp[h]; // [RQ5]
          qcnt[h] <= '0;
        end else if (rec_push && (qcnt[h] != (DW+1)'(DEPTH) || pop[h])) begin
          qmem[h][qwp[h]] <= rec; // [RQ3] [RQ4]
          qwp[h] <= qwp[h] + 1'b1;
          if (pop[h]) qrp[h] <= qrp[h] + 1'b1;
          else qcnt[h] <= qcnt[h] + 1'b1;
        end else if (rec_push) begin
          ovf[h] <= 1'b1;
          if (!head_dnew[h]) begin
            qmem[h][qwp[h]] <= rec; // [RQ9]
            qwp[h] <= qwp[h] + 1'b1;
            qrp[h] <= qrp[h] + 1'b1;
          end
        end else if (pop[h]) begin
          qrp[h] <= qrp[h] + 1'b1;
          qcnt[h] <= qcnt[h] - 1'b1;
        end
      end
    end
  end

  // round-robin choice of the next head with a record
  agq_pkg::agq_tx_e tx_st;
  logic [1:0] last, sel, hh;
  logic found, to_pri;
  logic [HEADS-1:0] fb, due, due_clr;
  always_comb begin
    found = 1'b0;
    sel = last;
    hh = last;
    for (int i = 1; i <= HEADS; i++) begin
      hh = 2'(int'(last) + i);
      if (!found && head_en[hh] && qcnt[hh] != '0) begin
        found = 1'b1;
        sel = hh;
      end
    end
  end
  assign pop = (tx_st == agq_pkg::TX_IDLE && found) ? HEADS'(1) << sel : '0;
  always_comb begin
    due_clr = '0;
    if (tx_st == agq_pkg::TX_IDLE && found && fb[sel]) due_clr[sel] = due[sel];
    if (tx_st == agq_pkg::TX_SEND && tx_fail && !to_pri) due_clr[tx_head] = due[tx_head];
  end

  // transmitter: record held until the link answers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_st <= agq_pkg::TX_IDLE;
      tx_valid <= 1'b0;
      tx_head <= 2'h0;
      tx_dest <= 7'h00;
      tx_rec <= '0;
      to_pri <= 1'b0;
      last <= 2'h3;
      fb <= '0;
    end else if (ce) begin
      case (tx_st)
        agq_pkg::TX_IDLE: begin
          if (found) begin
            tx_rec <= qmem[sel][qrp[sel]]; // [RQ4]
            tx_head <= sel;
            last <= sel;
            tx_valid <= 1'b1;
            tx_st <= agq_pkg::TX_SEND;
            to_pri <= !fb[sel] || due[sel];
            tx_dest <= (!fb[sel] || due[sel]) ? head_pri[sel] : head_sec[sel]; // [RQ6] [RQ8]
          end
        end
        agq_pkg::TX_SEND: begin
          if (tx_ok) begin
            tx_valid <= 1'b0;
            tx_st <= agq_pkg::TX_IDLE;
            if (to_pri) fb[tx_head] <= 1'b0; // [RQ8]
          end else if (tx_fail) begin
            tx_valid <= 1'b0;
            tx_st <= agq_pkg::TX_GAP;
            if (to_pri) fb[tx_head] <= 1'b1; // [RQ7]
            to_pri <= !to_pri && due[tx_head];
            tx_dest <= (!to_pri && due[tx_head]) ? head_pri[tx_head] : head_sec[tx_head]; // [RQ7]
          end
        end
        agq_pkg::TX_GAP: begin
          tx_valid <= 1'b1;
          tx_st <= agq_pkg::TX_SEND;
        end
        default: tx_st <= agq_pkg::TX_IDLE;
      endcase
    end
  end

  // fallback retry timers; the timer's set wins over a clear
  logic [15:0] rt_cnt [HEADS];
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      due <= '0;
      for (int h = 0; h < HEADS; h++) rt_cnt[h] <= 16'h0000;
    end else if (ce) begin
      for (int h = 0; h < HEADS; h++) begin
        if (!fb[h]) begin
          rt_cnt[h] <= 16'h0000;
          due[h] <= 1'b0;
        end else begin
          if (due_clr[h]) due[h] <= 1'b0;
          if (tick) begin
            rt_cnt[h] <= rt_cnt[h] == 16'(agq_pkg::RETRY_MS - 1) ? 16'h0000 : rt_cnt[h] + 16'h0001;
            if (rt_cnt[h] == 16'(agq_pkg::RETRY_MS - 1)) due[h] <= 1'b1; // [RQ8]
          end
        end
      end
    end
  end

  // alarm sequences: unacked flashes, acked holds until reset
  logic [K-1:0] unack, ackd, act, act_q;
  logic [15:0] fl_cnt;
  logic flash;
  assign act = unack | ackd | abn;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      unack <= '0;
      ackd <= '0;
      buzzer <= 1'b0;
      lamp <= '0;
    end else if (ce) begin
      for (int k = 0; k < K; k++) begin
        if (seq_mode == agq_pkg::SEQ_FOLLOW) begin
          unack[k] <= 1'b0;
          ackd[k] <= 1'b0;
        end else begin
          if (ack_p && unack[k]) begin
            unack[k] <= 1'b0;
            ackd[k] <= 1'b1;
          end else if (ackd[k] && !abn[k] && (seq_mode == agq_pkg::SEQ_AUTO || rst_p)) begin
            ackd[k] <= 1'b0; // [RQ17]
          end
          if (rise[k]) unack[k] <= 1'b1; // [RQ17]
        end
        lamp[k] <= unack[k] ? flash : (ackd[k] | abn[k]); // [RQ21]
      end
      if (sil_p || ack_p) buzzer <= 1'b0;
      if (|rise) buzzer <= 1'b1; // [RQ21]
    end
  end

  // flash rate for unacknowledged lamps
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fl_cnt <= 16'h0000;
      flash <= 1'b0;
    end else if (ce && tick) begin
      fl_cnt <= fl_cnt == 16'(agq_pkg::FLASH_MS - 1) ? 16'h0000 : fl_cnt + 16'h0001;
      if (fl_cnt == 16'(agq_pkg::FLASH_MS - 1)) flash <= !flash;
    end
  end

  // group outputs
  agq_grp_if #(.N(N)) g1 ();
  agq_grp_if #(.N(N)) g2 ();
  assign g1.abn = abn[N-1:0]; // [RQ12]
  assign g1.act = act[N-1:0];
  assign g2.abn = abn[K-1:N]; // [RQ12]
  assign g2.act = act[K-1:N];
  assign g1.tick = tick;
  assign g2.tick = tick;
  assign g1.mode = ga_mode; // [RQ13]
  assign g2.mode = ga_mode;
  agq_group_out #(.N(N)) u_ga1 (.clk(clk), .sys_rst(sys_rst), .ce(ce), .g(g1));
  agq_group_out #(.N(N)) u_ga2 (.clk(clk), .sys_rst(sys_rst), .ce(ce), .g(g2));
  assign group_alarm_output = {g2.energised, g1.energised};

  // auto-scroll; a new alarm jumps to its input
  logic [15:0] scr_cnt;
  logic [KW:0] rise_first;
  assign rise_first = first_set(rise);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scr_cnt <= 16'h0000;
      disp_input <= 4'h0;
    end else if (ce) begin
      if (rise_first[KW]) begin
        disp_input <= 4'(int'(rise_first[KW-1:0]) % N);
        scr_cnt <= 16'h0000;
      end else if (scr_mode == agq_pkg::SCR_OFF) begin
        scr_cnt <= 16'h0000; // [RQ18]
      end else if (tick) begin
        if (scr_cnt >= 16'(scr_mode == agq_pkg::SCR_5S ? agq_pkg::SCROLL5_MS - 1
                                                      : agq_pkg::SCROLL15_MS - 1)) begin
          scr_cnt <= 16'h0000;
          disp_input <= int'(disp_input) == N - 1 ? 4'h0 : disp_input + 4'h1; // [RQ18]
        end else begin
          scr_cnt <= scr_cnt + 16'h0001;
        end
      end
    end
  end

  // status table kept from live state
  logic [15:0] st_word [agq_pkg::ST_WORDS];
  assign st_word[0] = 16'(abn[N-1:0]); // [RQ10]
  assign st_word[1] = 16'(abn[K-1:N]);
  assign st_word[2] = 16'(act[N-1:0]);
  assign st_word[3] = 16'(act[K-1:N]);
  assign st_word[4] = {11'h000, buzzer, disp_input[3:0] == 4'h0, 1'b0, group_alarm_output};
  assign st_word[5] = {4'h0, ovf, fb, due};

  // change flag for subscribing peers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      act_q <= '0;
      table_change <= 1'b0;
    end else if (ce) begin
      act_q <= act;
      table_change <= |chg || act != act_q; // [RQ11]
    end
  end

  // read mux; unmapped reads give zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_addr == agq_pkg::A_CTRL) begin
      next_rdata = {26'h0, scr_mode, seq_mode, ga_mode};
    end else if (reg_addr == agq_pkg::A_NODE) begin
      next_rdata = {25'h0, node_addr};
    end else if (reg_addr == agq_pkg::A_HYST) begin
      next_rdata = {16'h0, hyst};
    end else if (reg_addr == agq_pkg::A_SPTYPE) begin
      next_rdata = 32'(sp_type);
    end else if (hd_off < 12'(4 * HEADS) && hd_off[1:0] == 2'h0) begin
      next_rdata = {14'h0, head_dnew[hd_idx], head_en[hd_idx], 1'b0, head_sec[hd_idx],
                    1'b0, head_pri[hd_idx]};
    end else if (reg_addr >= agq_pkg::A_STAT && reg_addr < agq_pkg::A_STAT
                 + 12'(4 * agq_pkg::ST_WORDS) && reg_addr[1:0] == 2'h0) begin
      next_rdata = {16'h0, st_word[3'(int'(reg_addr - agq_pkg::A_STAT) / 4)]}; // [RQ10]
    end else if (sp_off < 12'(4 * K) && sp_off[1:0] == 2'h0) begin
      next_rdata = {16'h0, sp_val[sp_idx]};
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) reg_rdata <= 32'h0000_0000;
    else if (ce) reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
  end
endmodule : agq_top

/* dv/agq_top_assertions.sv */
/* port checker for agq_top.
   assumes sync reset, bound below. */
`timescale 1ns/1ns
module agq_chk (
  // clocking
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // link
  input wire logic tx_valid,
  input wire logic [6:0] tx_dest,
  input wire agq_pkg::agq_rec_s tx_rec,
  input wire logic tx_ok,
  input wire logic tx_fail
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_rd_idle: assert property ($past(ce) && !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("rdata not zero");
  a_rd_hole: assert property (ce && reg_rd && reg_addr == 12'h020 |=> reg_rdata == 32'h0)
    else $error("hole not zero");
  a_node_width: assert property (ce && reg_rd && reg_addr == 12'h004 |=> !reg_rdata[31:7])
    else $error("node too wide");
  // offer holds until answered
  a_tx_hold: assert property (ce && tx_valid && !tx_ok && !tx_fail |=> tx_valid
    && $stable(tx_rec) && $stable(tx_dest)) else $error("offer changed");
  a_tx_done: assert property (ce && tx_valid && tx_ok |=> !tx_valid)
    else $error("valid after ok");
  a_tx_retry: assert property (ce && tx_valid && tx_fail |=> !tx_valid ##1
    (tx_valid && tx_rec == $past(tx_rec, 2))) else $error("no resend");
  a_rec_type: assert property (tx_valid |-> tx_rec.rtype == 8'h01
    && (tx_rec.state == 8'hFF || tx_rec.state == 8'h00)) else $error("bad type or state");
  a_rec_range: assert property (tx_valid |-> tx_rec.word < 16'h0CB2 && tx_rec.bitn < 8'h10
    && tx_rec.node != 8'h00 && tx_rec.node < 8'h80) else $error("bad field");
  c_ok: cover property (tx_valid && tx_ok);
  c_fail: cover property (tx_valid && tx_fail);
  c_hole: cover property (reg_rd && reg_addr == 12'h020);
endmodule : agq_chk
bind agq_top agq_chk u_chk (.clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_valid(tx_valid), .tx_dest(tx_dest),
  .tx_rec(tx_rec), .tx_ok(tx_ok), .tx_fail(tx_fail));

/* dv/agq_link_model.sv */
/* link model answering record offers.
   assumes offers held until answered. */
`timescale 1ns/1ns
module agq_link_model (
  // clocking
  input wire logic clk,
  // link
  input wire logic tx_valid,
  input wire logic [6:0] tx_dest,
  output logic tx_ok,
  output logic tx_fail,
  // faults
  input wire logic [6:0] bad_dest,
  input wire logic [3:0] dly
);
  logic [3:0] cnt = 4'h0;
  logic go;
  // answer dly+1 cycles after the offer; dead node fails
  assign go = tx_valid && !tx_ok && !tx_fail;
  always @(posedge clk) begin
    cnt <= go ? cnt + 4'h1 : 4'h0;
    tx_ok <= go && cnt >= dly && tx_dest != bad_dest;
    tx_fail <= go && cnt >= dly && tx_dest == bad_dest;
  end
endmodule : agq_link_model

/* dv/agq_top_tb.sv */
/* agq_top bench.
   assumes the bound checker and link model. */
`timescale 1ns/1ns
module agq_top_tb;
  logic clk, sys_rst, reg_wr, reg_rd, in_valid, tx_valid, tx_ok, tx_fail, rd_d, ce, key;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, in_value, rq[$];
  logic [1:0] tx_head, ga;
  logic [6:0] tx_dest, bad_dest, node, pri[4], sec[4], dst[4];
  logic [3:0] dly, en;
  logic [118:0] hq[4][$];
  agq_pkg::agq_time_s rtc_now;
  agq_pkg::agq_rec_s tx_rec;
  int miscompares = 0, n_tests = 0;
  agq_top #(.N(2), .DEPTH(8), .TICK_CYC(4)) DUT (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .in_value(in_value), .in_valid(in_valid), .rtc_now(rtc_now),
    .key_silence(key), .key_ack(key), .key_reset(key), .tx_valid(tx_valid),
    .tx_head(tx_head), .tx_dest(tx_dest), .tx_rec(tx_rec), .tx_ok(tx_ok), .tx_fail(tx_fail),
    .group_alarm_output(ga), .lamp(), .buzzer(), .disp_input(), .table_change());
  agq_link_model u_link (.clk(clk), .tx_valid(tx_valid), .tx_dest(tx_dest), .tx_ok(tx_ok),
    .tx_fail(tx_fail), .bad_dest(bad_dest), .dly(dly));
  task automatic chk(input logic [118:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("tests %0d errors %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, logic [31:0] e);
    rq.push_back(e);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd
  // setpoint 1 crossing of input i
  task automatic ev(input int i, logic a);
    agq_pkg::agq_rec_s r;
    r = {8'h01, {$urandom, $urandom}, 16'h0, 8'(i), a ? 8'hFF : 8'h00, 1'b0, node};
    for (int h = 0; h < 4; h++) if (en[h]) hq[h].push_back({dst[h], r});
    @(posedge clk);
    in_value[16*i +: 16] <= {1'b0, a, 14'($urandom)};
    {rtc_now, in_valid, dly} <= {r.stamp, 1'b1, 4'($urandom)};
    @(posedge clk);
    in_valid <= 1'b0;
    repeat (100) @(posedge clk);
    chk(hq[0].size() + hq[1].size() + hq[2].size() + hq[3].size(), 0);
  endtask : ev
  // head h: primary, secondary, enable, drop old
  task automatic head(input int h);
    wr(12'h010 + 12'(4*h), {15'h0, en[h], 1'b0, sec[h], 1'b0, pri[h]});
  endtask : head
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // oldest note against result
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) chk(reg_rdata, rq.pop_front());
    if (tx_valid && tx_ok) chk({tx_dest, tx_rec}, hq[tx_head].pop_front());
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop;
  end
  initial begin
    {ce, sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata, in_value, in_valid} = 2'b11 << 79;
    {rtc_now, bad_dest, dly, en, rd_d, key} = '0;
    void'($urandom(12325));
    node = 7'($urandom % 127 + 1);
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(12'h004, 1);
    rd(12'h020, 0);
    wr(12'h004, node);
    for (int k = 0; k < 4; k++) wr(12'h100 + 12'(4*k), {k[1], 15'h4000});
    en = 4'h1;
    for (int h = 0; h < 4; h++) begin
      {pri[h], sec[h], dst[h]} = {7'(h+10), 7'(h+20), 7'(h+10)};
      head(h);
    end
    ev(0, 1'b1);
    chk(ga, 2'b10);
    wr(12'h040, 32'hFFFF);
    rd(12'h040, 1);
    ev(0, 1'b0);
    chk(ga, 2'b11);
    bad_dest <= pri[0];
    dst[0] = sec[0];
    ev(1, 1'b1);
    bad_dest <= 7'h00;
    ev(1, 1'b0);
    repeat (4200) @(posedge clk);
    dst[0] = pri[0];
    ev(0, 1'b1);
    en = 4'h2;
    head(0);
    head(1);
    ev(1, 1'b1);
    en = 4'h3;
    head(0);
    ev(0, 1'b0);
    report_and_stop;
  end
endmodule : agq_top_tb
